// File: lcd_i2c_top.sv
//Contract
// - address, control, address byte, then data
// - answer only fixed address plus select pin
// - read direction bit gets no acknowledge
// - general call address is not acknowledged
// - control bit 0 switches display on
// - control bit 1 enters power save
// - control bit 2 selects static icon mode
// - control bit 3 picks 1/34 or 1/17
// - control bit 4 picks bias, icon forces 1/2
// - control bits 7..5 load page address
// - power save beats icon beats normal
// - address bit 7 selects page increment
// - data byte written, then address advances
// - commands accepted during wait, host delays on; code ignores the bus until ready
// - reset low 10us, ready 1us after release
// - one frame per 136 oscillator periods
// - acknowledge on ninth clock of good bytes
// - column mode wraps column then page
// - page mode wraps page then column
// - stop ends reception, settings kept
`timescale 1ns/1ps
module lcd_i2c_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic disp_osc_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin,
  output logic ready,
  output logic display_on,
  output logic power_save,
  output logic icon_mode,
  output logic duty_34,
  output lcd_pkg::lcd_bias_type bias_sel,
  output logic [2:0] page_addr,
  output logic [6:0] column_addr,
  output logic page_inc_mode,
  output logic [lcd_pkg::SEG_COUNT-1:0] segment_outputs,
  output logic [5:0] com_index,
  output logic com_drive_en,
  output logic com_half_level,
  output logic frame_fr
);
  // Reset release pipeline
  logic [1:0] rst_sync_r;
  logic rst_sync_n;
  // Completion of internal reset
  logic [lcd_pkg::RESET_CNT_W-1:0] rst_cnt_r;
  logic ready_r;
  // Pin synchronisers; stage one feeds only stage two
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;
  logic sel_s1_r, sel_s2_r;
  // Bus events
  logic scl_rise, scl_fall, start_det, stop_det;
  // Receiver state
  lcd_pkg::lcd_rx_type state_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  // High through the acknowledge clock
  logic ack_phase_r;
  logic byte_done;
  // Address matched and direction is write
  logic addr_ok;
  // Latched settings
  logic [7:0] ctrl_r;
  logic [2:0] page_r, page_nxt;
  logic [6:0] col_r, col_nxt;
  logic inc_mode_r;
  // RAM write enable, read row and read data
  logic ram_we;
  logic [lcd_pkg::ROW_W-1:0] ram_row;
  logic [lcd_pkg::SEG_COUNT-1:0] ram_rdata;

  // Asynchronous assert, release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_sync_n = rst_sync_r[1];

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rst_cnt_r <= '0;
      ready_r <= 1'b0;
    end else if (!ready_r) begin
      if (rst_cnt_r >= lcd_pkg::RESET_CNT_W'(lcd_pkg::RESET_DONE_CYC - 1)) ready_r <= 1'b1;
      else rst_cnt_r <= rst_cnt_r + 8'h01;
    end
  end
  // Ready gates the receiver; earlier bytes are ignored
  assign ready = ready_r;

  // Bus pins come from outside, two flops before use
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      // Idle bus level, so no false edge after reset
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
      sel_s1_r <= 1'b0;
      sel_s2_r <= 1'b0;
    end else begin
      // Each pin copy moves one stage along
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      // Same delay as the clock keeps START and STOP aligned
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
      // Strapped pin, but still crossed in
      sel_s1_r <= addr_select_pin;
      sel_s2_r <= sel_s1_r;
    end
  end

  // Edge and condition detection on the synchronised copies
  // Third stage holds the previous level for edges
  assign scl_rise = scl_s2_r && !scl_d_r;
  assign scl_fall = !scl_s2_r && scl_d_r;
  // START: data falls while clock high
  assign start_det = scl_s2_r && scl_d_r && !sda_s2_r && sda_d_r;
  // STOP: data rises while clock high
  assign stop_det = scl_s2_r && scl_d_r && sda_s2_r && !sda_d_r;

  // Eight bits in, decision made on the following clock fall
  // The acknowledge clock never counts as a data bit
  assign byte_done = scl_fall && (bit_cnt_r == 4'h8) && !ack_phase_r;

  // fixed upper bits plus select pin
  assign addr_ok = (shift_r[7:2] == lcd_pkg::SLAVE_ADDR_HI) && (shift_r[1] == sel_s2_r)
                   && !shift_r[0] && (shift_r[7:1] != lcd_pkg::GENERAL_CALL_ADDR);

  // Byte sequencing
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= lcd_pkg::ST_IDLE;
    end else if (!ready_r) begin
      // Bus ignored until internal reset completes
      state_r <= lcd_pkg::ST_IDLE;
    end else if (start_det) begin
      // Repeated start restarts with the address byte
      state_r <= lcd_pkg::ST_SLAVE_ADDR;
    end else if (stop_det) begin
      state_r <= lcd_pkg::ST_IDLE;
    end else if (byte_done) begin
      case (state_r)
        lcd_pkg::ST_SLAVE_ADDR: state_r <= addr_ok ? lcd_pkg::ST_CONTROL : lcd_pkg::ST_IGNORE;
        lcd_pkg::ST_CONTROL: state_r <= lcd_pkg::ST_ADDRESS;
        lcd_pkg::ST_ADDRESS: state_r <= lcd_pkg::ST_DATA;
        // Data continues until STOP or START
        lcd_pkg::ST_DATA: state_r <= lcd_pkg::ST_DATA;
        // Idle and ignore wait for START
        default: state_r <= state_r;
      endcase
    end
  end

  // Bit counter and shifter, sampled on clock rise
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      ack_phase_r <= 1'b0;
    end else if (start_det || stop_det || !ready_r) begin
      bit_cnt_r <= 4'h0;
      ack_phase_r <= 1'b0;
    end else if (scl_fall && ack_phase_r) begin
      // End of ninth clock, next byte begins
      bit_cnt_r <= 4'h0;
      ack_phase_r <= 1'b0;
    end else if (byte_done) begin
      // Ninth clock belongs to the acknowledge
      ack_phase_r <= 1'b1;
    // Data bit taken while the clock is high
    end else if (scl_rise && bit_cnt_r < 4'h8) begin
      shift_r <= {shift_r[6:0], sda_s2_r};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sda_oe <= 1'b0;
    end else if (start_det || stop_det || !ready_r) begin
      sda_oe <= 1'b0;
    end else if (scl_fall && ack_phase_r) begin
      sda_oe <= 1'b0;
    end else if (byte_done) begin
      case (state_r)
        // Address byte answered only on a match
        lcd_pkg::ST_SLAVE_ADDR: sda_oe <= addr_ok;
        lcd_pkg::ST_CONTROL, lcd_pkg::ST_ADDRESS, lcd_pkg::ST_DATA: sda_oe <= 1'b1;
        // Idle and ignored bytes get no answer
        default: sda_oe <= 1'b0;
      endcase
    end
  end
  // Open drain: only ever pulls low
  assign sda_out = 1'b0;

  // settings latch only on a whole byte
  // commands accepted at any time once ready is high
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_r <= lcd_pkg::CTRL_RESET;
    end else if (byte_done && state_r == lcd_pkg::ST_CONTROL) begin
      ctrl_r <= shift_r;
    end
  end

  // Address advance for the current mode
  always_comb begin
    // Default hold; the other pointer moves only on a wrap
    page_nxt = page_r;
    col_nxt = col_r;
    if (!inc_mode_r) begin
      if (col_r >= lcd_pkg::COL_MAX) begin
        col_nxt = 7'h00;
        page_nxt = (page_r >= lcd_pkg::PAGE_MAX) ? 3'h0 : page_r + 3'h1;
      end else begin
        col_nxt = col_r + 7'h01;
      end
    end else begin
      if (page_r >= lcd_pkg::PAGE_MAX) begin
        page_nxt = 3'h0;
        col_nxt = (col_r >= lcd_pkg::COL_MAX) ? 7'h00 : col_r + 7'h01;
      end else begin
        page_nxt = page_r + 3'h1;
      end
    end
  end

  // Page, column and increment mode
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      page_r <= lcd_pkg::CTRL_RESET[lcd_pkg::CTRL_PAGE_MSB:lcd_pkg::CTRL_PAGE_LSB];
      col_r <= lcd_pkg::ADDR_RESET[lcd_pkg::ADDR_COL_MSB:0];
      inc_mode_r <= lcd_pkg::ADDR_RESET[lcd_pkg::ADDR_INC_BIT];
    end else if (byte_done) begin
      case (state_r)
        lcd_pkg::ST_CONTROL: page_r <= shift_r[lcd_pkg::CTRL_PAGE_MSB:lcd_pkg::CTRL_PAGE_LSB];
        // Address byte sets mode and column
        lcd_pkg::ST_ADDRESS: begin
          inc_mode_r <= shift_r[lcd_pkg::ADDR_INC_BIT];
          col_r <= shift_r[lcd_pkg::ADDR_COL_MSB:0];
        end
        lcd_pkg::ST_DATA: begin
          page_r <= page_nxt;
          col_r <= col_nxt;
        end
        default: begin
          // Slave address byte moves nothing
          page_r <= page_r;
        end
      endcase
    end
  end

  // write at current page and column
  // Out-of-range addresses write nothing, so no foreign row is hit
  assign ram_we = byte_done && (state_r == lcd_pkg::ST_DATA)
                  && (page_r <= lcd_pkg::PAGE_MAX) && (col_r <= lcd_pkg::COL_MAX);

  // Writes on the core clock, reads on the display oscillator
  lcd_ram u_ram (
    .wclk(core_clk),
    .we(ram_we),
    .wpage(page_r),
    .wcol(col_r),
    .wdata(shift_r),
    // Read side never stalls the bus writer
    .rclk(disp_osc_clk),
    .rrow(ram_row),
    .rdata(ram_rdata)
  );

  // Settings as seen by the display side
  assign display_on = ctrl_r[lcd_pkg::CTRL_DISP_ON_BIT];
  assign power_save = ctrl_r[lcd_pkg::CTRL_PSAVE_BIT];
  assign icon_mode = ctrl_r[lcd_pkg::CTRL_ICON_BIT] && !power_save;
  // Duty passed through; icon mode overrides it downstream
  assign duty_34 = ctrl_r[lcd_pkg::CTRL_DUTY_BIT];
  // Pointers shown as registered
  assign page_addr = page_r;
  assign column_addr = col_r;
  assign page_inc_mode = inc_mode_r;

  always_comb begin
    if (icon_mode) bias_sel = lcd_pkg::BIAS_1_2;
    else if (ctrl_r[lcd_pkg::CTRL_BIAS_BIT]) bias_sel = lcd_pkg::BIAS_1_7;
    // Normal mode with bias bit clear
    else bias_sel = lcd_pkg::BIAS_1_5;
  end

  // Scan, latch and output drive in the oscillator domain
  lcd_timing u_timing (
    .osc_clk(disp_osc_clk),
    // Core reset copy; oscillator side adds its own stages
    .rst_n(rst_sync_n),
    .display_on(display_on),
    .power_save(power_save),
    .icon_mode(icon_mode),
    .duty_34(duty_34),
    .ram_row(ram_row),
    .ram_rdata(ram_rdata),
    .segment_outputs(segment_outputs),
    .com_index(com_index),
    .com_drive_en(com_drive_en),
    .com_half_level(com_half_level),
    .frame_fr(frame_fr)
  );
endmodule : lcd_i2c_top

// File: lcd_pkg.sv
package lcd_pkg;
  // Core clock period and reset completion time
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_DONE_NS = 1000;
  // Least time rounds up to whole cycles
  localparam int RESET_DONE_CYC = (RESET_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_W = 8;

  // Fixed upper six bits of the slave address
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h1C;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

  // Control byte field positions
  localparam int CTRL_DISP_ON_BIT = 0;
  localparam int CTRL_PSAVE_BIT = 1;
  localparam int CTRL_ICON_BIT = 2;
  localparam int CTRL_DUTY_BIT = 3;
  localparam int CTRL_BIAS_BIT = 4;
  localparam int CTRL_PAGE_LSB = 5;
  localparam int CTRL_PAGE_MSB = 7;
  // Address byte field positions
  localparam int ADDR_INC_BIT = 7;
  localparam int ADDR_COL_MSB = 6;

  // Reset values of latched settings
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;

  // Display RAM geometry
  localparam logic [2:0] PAGE_MAX = 3'h4;
  localparam logic [6:0] COL_MAX = 7'h64;
  localparam int SEG_COUNT = 101;
  localparam int RAM_ROWS = 40;
  localparam int ROW_W = 6;
  localparam int BITS_PER_PAGE = 8;

  // Display timing
  localparam int FRAME_OSC = 136;
  localparam int LINES_DUTY34 = 34;
  localparam int LINES_DUTY17 = 17;
  localparam logic [5:0] ICON_COM = 6'h21;
  localparam logic [5:0] LAST_LOW_COM = 6'h0F;
  localparam int OSC_CNT_W = 8;

  // Bias ratio handed to the analog supply
  typedef enum logic [1:0] {BIAS_1_5, BIAS_1_7, BIAS_1_2} lcd_bias_type;
  // Receiver byte phases
  typedef enum logic [2:0] {ST_IDLE, ST_SLAVE_ADDR, ST_CONTROL, ST_ADDRESS, ST_DATA, ST_IGNORE} lcd_rx_type;
endpackage : lcd_pkg

// File: lcd_ram.sv
`timescale 1ns/1ps
module lcd_ram #(
  parameter int ROWS = lcd_pkg::RAM_ROWS,
  parameter int COLS = lcd_pkg::SEG_COUNT
) (
  input wire logic wclk,
  input wire logic we,
  input wire logic [2:0] wpage,
  input wire logic [6:0] wcol,
  input wire logic [7:0] wdata,
  input wire logic rclk,
  input wire logic [lcd_pkg::ROW_W-1:0] rrow,
  output logic [COLS-1:0] rdata
);
  // One word per common line, one bit per segment
  logic [COLS-1:0] mem [ROWS];

  // Byte write lands as one bit in eight consecutive lines
  always_ff @(posedge wclk) begin
    if (we) begin
      for (int k = 0; k < lcd_pkg::BITS_PER_PAGE; k++) begin
        mem[{wpage, 3'(k)}][wcol] <= wdata[k];
      end
    end
  end

  // Registered read on the display clock, independent of writes
  always_ff @(posedge rclk) begin
    rdata <= mem[rrow];
  end
endmodule : lcd_ram

// File: lcd_timing.sv
`timescale 1ns/1ps
module lcd_timing (
  input wire logic osc_clk,
  input wire logic rst_n,
  input wire logic display_on,
  input wire logic power_save,
  input wire logic icon_mode,
  input wire logic duty_34,
  output logic [lcd_pkg::ROW_W-1:0] ram_row,
  input wire logic [lcd_pkg::SEG_COUNT-1:0] ram_rdata,
  output logic [lcd_pkg::SEG_COUNT-1:0] segment_outputs,
  output logic [5:0] com_index,
  output logic com_drive_en,
  output logic com_half_level,
  output logic frame_fr
);
  // Reset released locally so the oscillator domain leaves reset cleanly
  logic [1:0] rst_pipe_r;
  logic orst_n;
  // Two-flop synchronisers for the four mode levels
  logic [3:0] mode_in;
  logic [3:0] mode_s1_r;
  logic [3:0] mode_s2_r;
  logic on_s, ps_s, icon_s, d34_s;
  logic [lcd_pkg::OSC_CNT_W-1:0] tick_r, line_len;
  logic [5:0] line_r, lines, cur_com;
  logic last_tick, last_line, drive;

  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) rst_pipe_r <= 2'h0;
    else rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end
  assign orst_n = rst_pipe_r[1];

  assign mode_in = {duty_34, icon_mode, power_save, display_on};
  // Settings are levels, so plain two-flop crossing is enough
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge osc_clk or negedge orst_n) begin
      if (!orst_n) begin
        mode_s1_r[i] <= 1'b0;
        mode_s2_r[i] <= 1'b0;
      end else begin
        mode_s1_r[i] <= mode_in[i];
        mode_s2_r[i] <= mode_s1_r[i];
      end
    end
  end
  assign on_s = mode_s2_r[0];
  assign ps_s = mode_s2_r[1];
  assign icon_s = mode_s2_r[2];
  assign d34_s = mode_s2_r[3];

  always_comb begin
    if (icon_s) begin
      lines = 6'h01;
      line_len = lcd_pkg::OSC_CNT_W'(lcd_pkg::FRAME_OSC);
    end else if (d34_s) begin
      lines = 6'(lcd_pkg::LINES_DUTY34);
      line_len = lcd_pkg::OSC_CNT_W'(lcd_pkg::FRAME_OSC / lcd_pkg::LINES_DUTY34);
    end else begin
      lines = 6'(lcd_pkg::LINES_DUTY17);
      line_len = lcd_pkg::OSC_CNT_W'(lcd_pkg::FRAME_OSC / lcd_pkg::LINES_DUTY17);
    end
  end
  assign last_tick = (tick_r >= line_len - 8'h01);
  assign last_line = (line_r >= lines - 6'h01);

  always_ff @(posedge osc_clk or negedge orst_n) begin
    if (!orst_n) begin
      tick_r <= 8'h00;
      line_r <= 6'h00;
      frame_fr <= 1'b0;
    end else if (ps_s) begin
      // Oscillator stopped in power save: scan parked at tick 0, line 0
      tick_r <= 8'h00;
      line_r <= 6'h00;
    end else if (last_tick) begin
      tick_r <= 8'h00;
      line_r <= last_line ? 6'h00 : line_r + 6'h01;
      if (last_line) frame_fr <= ~frame_fr;
    end else begin
      tick_r <= tick_r + 8'h01;
    end
  end

  always_comb begin
    if (icon_s) cur_com = lcd_pkg::ICON_COM;
    else if (d34_s || line_r <= lcd_pkg::LAST_LOW_COM) cur_com = line_r;
    else cur_com = lcd_pkg::ICON_COM;
  end
  assign ram_row = cur_com;

  assign drive = on_s && !ps_s;
  // Line data arrives one clock after the row address
  always_ff @(posedge osc_clk or negedge orst_n) begin
    if (!orst_n) begin
      segment_outputs <= '0;
      com_index <= 6'h00;
      com_drive_en <= 1'b0;
      com_half_level <= 1'b0;
    end else begin
      com_drive_en <= drive;
      // icon mode other commons at half
      com_half_level <= drive && icon_s;
      com_index <= cur_com;
      if (!drive) segment_outputs <= '0;
      else if (tick_r == 8'h01) segment_outputs <= ram_rdata;
    end
  end
endmodule : lcd_timing

// File: lcd_i2c_master_model.sv
`timescale 1ns/1ps
// Bus master: changes lines on the falling core edge
module lcd_i2c_master_model (
  input wire logic clk,
  output logic scl_o,
  output logic sda_low,
  input wire logic sda_wire
);
  // Quarter bit in core cycles, gives SCL of about 833 kHz
  localparam int Q = 30;
  initial begin
    scl_o = 1'b1;
    sda_low = 1'b0;
  end
  task automatic qw(input int n);
    repeat (n * Q) @(negedge clk);
  endtask : qw
  task automatic start();
    sda_low = 1'b0;
    qw(1);
    scl_o = 1'b1;
    qw(1);
    sda_low = 1'b1;
    qw(1);
    scl_o = 1'b0;
    qw(1);
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    qw(1);
    scl_o = 1'b1;
    qw(1);
    sda_low = 1'b0;
    qw(2);
  endtask : stop
  // MSB first, data moves only while SCL is low
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      sda_low = !b[7-i];
      qw(1);
      scl_o = 1'b1;
      qw(2);
      scl_o = 1'b0;
      qw(1);
    end
  endtask : send_bits
  task automatic send_byte(input logic [7:0] b, output logic ack);
    send_bits(b, 8);
    sda_low = 1'b0;
    qw(1);
    scl_o = 1'b1;
    qw(1);
    ack = !sda_wire;
    qw(1);
    scl_o = 1'b0;
    qw(1);
  endtask : send_byte
endmodule : lcd_i2c_master_model

// File: lcd_i2c_checker.sv
`timescale 1ns/1ps
// Bus answer and mode output relations
module lcd_i2c_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic disp_osc_clk,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic ready,
  input wire logic power_save,
  input wire logic icon_mode,
  input wire lcd_pkg::lcd_bias_type bias_sel,
  input wire logic [2:0] page_addr,
  input wire logic [6:0] column_addr,
  input wire logic [lcd_pkg::SEG_COUNT-1:0] segment_outputs,
  input wire logic [5:0] com_index,
  input wire logic com_drive_en,
  input wire logic com_half_level
);
  // Cycles since reset release, saturates
  logic [7:0] rel_cnt_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rel_cnt_r <= 8'h00;
    end else if (rel_cnt_r != 8'hFF) begin
      rel_cnt_r <= rel_cnt_r + 8'h01;
    end
  end
  // Ack high when the ninth clock falls
  sequence s_ack_end;
    sda_oe ##1 $fell(scl_in);
  endsequence
  property p_open_drain;
    @(posedge core_clk) disable iff (!rst_n) sda_oe |-> sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
  property p_ack_start;
    @(posedge core_clk) disable iff (!rst_n) $rose(sda_oe) |-> !scl_in && ready;
  endproperty
  a_ack_start: assert property (p_ack_start) else $error("ack at wrong time");
  property p_ack_end;
    @(posedge core_clk) disable iff (!rst_n) s_ack_end |-> ##[1:6] !sda_oe;
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack held too long");
  property p_ready_late;
    @(posedge core_clk) disable iff (!rst_n) ready |-> rel_cnt_r >= 8'h64;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too early");
  // Pointers move only while SCL is low, never on STOP
  property p_ptr_hold;
    @(posedge core_clk) disable iff (!rst_n) scl_in |-> $stable(page_addr) && $stable(column_addr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
  property p_icon_ps;
    @(posedge core_clk) disable iff (!rst_n) icon_mode |-> !power_save;
  endproperty
  a_icon_ps: assert property (p_icon_ps) else $error("icon during save");
  property p_bias;
    @(posedge core_clk) disable iff (!rst_n) (bias_sel == lcd_pkg::BIAS_1_2) |-> icon_mode;
  endproperty
  a_bias: assert property (p_bias) else $error("half bias outside icon");
  // Two cycles slack for the synchroniser
  property p_seg_dark;
    @(posedge disp_osc_clk) disable iff (!rst_n) !com_drive_en [*3] |-> segment_outputs == '0;
  endproperty
  a_seg_dark: assert property (p_seg_dark) else $error("segments lit while off");
  property p_half_drive;
    @(posedge disp_osc_clk) disable iff (!rst_n) com_half_level |-> com_drive_en;
  endproperty
  a_half_drive: assert property (p_half_drive) else $error("half level while off");
  property p_half_com;
    @(posedge disp_osc_clk) disable iff (!rst_n) com_half_level |-> com_index == lcd_pkg::ICON_COM;
  endproperty
  a_half_com: assert property (p_half_com) else $error("half level off icon common");
endmodule : lcd_i2c_checker
bind lcd_i2c_top lcd_i2c_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .disp_osc_clk(disp_osc_clk),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .ready(ready), .power_save(power_save),
  .icon_mode(icon_mode), .bias_sel(bias_sel), .page_addr(page_addr), .column_addr(column_addr),
  .segment_outputs(segment_outputs), .com_index(com_index), .com_drive_en(com_drive_en),
  .com_half_level(com_half_level));

// File: lcd_i2c_command_port_tb.sv
`timescale 1ns/1ps
module lcd_i2c_command_port_tb;
  logic core_clk = 1'b0;
  logic osc_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, ready, display_on, power_save, icon_mode, duty_34, page_inc_mode;
  logic com_drive_en, com_half_level, frame_fr;
  lcd_pkg::lcd_bias_type bias_sel;
  logic [2:0] page_addr;
  logic [6:0] column_addr;
  logic [5:0] com_index;
  logic [lcd_pkg::SEG_COUNT-1:0] segment_outputs;
  // Pull-up wire: low if anyone pulls
  wire sda_wire = !(sda_low || (sda_oe && !sda_out));
  int error_cnt = 0;
  int compares = 0;
  localparam logic [7:0] SLV0 = {lcd_pkg::SLAVE_ADDR_HI, 2'b00};
  localparam logic [7:0] SLV1 = {lcd_pkg::SLAVE_ADDR_HI, 2'b10};
  always #5 core_clk = ~core_clk;
  // Free running oscillator, offset phase
  initial begin
    #37;
    forever #80 osc_clk = ~osc_clk;
  end
  lcd_i2c_top dut (.core_clk(core_clk), .rst_n(rst_n), .disp_osc_clk(osc_clk), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(sel), .ready(ready), .display_on(display_on),
    .power_save(power_save), .icon_mode(icon_mode), .duty_34(duty_34), .bias_sel(bias_sel),
    .page_addr(page_addr), .column_addr(column_addr), .page_inc_mode(page_inc_mode),
    .segment_outputs(segment_outputs), .com_index(com_index), .com_drive_en(com_drive_en),
    .com_half_level(com_half_level), .frame_fr(frame_fr));
  lcd_i2c_master_model m (.clk(core_clk), .scl_o(scl), .sda_low(sda_low), .sda_wire(sda_wire));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic send(input logic [7:0] b, input logic exp);
    logic a;
    m.send_byte(b, a);
    chk(16'(a), 16'(exp));
  endtask : send
  task automatic open(input logic [7:0] ctl);
    m.start();
    send(SLV0, 1'b1);
    send(ctl, 1'b1);
  endtask : open
  task automatic give_verdict();
    $display("Comparisons %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // Reset, cleared state, then wait for ready
  task automatic do_reset();
    int n;
    n = 0;
    rst_n = 1'b0;
    repeat (12) @(negedge core_clk);
    chk(16'({display_on, power_save, icon_mode, page_inc_mode, page_addr, column_addr, ready}), 16'h0000);
    rst_n = 1'b1;
    while (ready !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    chk(16'(n >= 100 && n <= 110), 16'h0001);
    chk(16'(bias_sel), 16'(lcd_pkg::BIAS_1_5));
  endtask : do_reset
  // Foreign, read and general call bytes get no answer
  task automatic t_slave();
    logic [7:0] tbl [4];
    tbl = '{SLV1, SLV0 | 8'h01, 8'h00, SLV0};
    for (int i = 0; i < 4; i++) begin
      m.start();
      send(tbl[i], i == 3);
      send(8'h01, i == 3);
      m.stop();
      chk(16'(display_on), 16'(i == 3));
    end
    sel = 1'b1;
    m.start();
    send(SLV1, 1'b1);
    m.stop();
    sel = 1'b0;
  endtask : t_slave
  // Every control field and the mode priority
  task automatic t_ctrl();
    logic [7:0] c [6];
    logic ic;
    c = '{8'h01, 8'h23, 8'h47, 8'h6D, 8'h99, 8'h14};
    foreach (c[i]) begin
      open(c[i]);
      m.stop();
      ic = c[i][2] && !c[i][1];
      chk(16'({display_on, power_save, duty_34}), 16'({c[i][0], c[i][1], c[i][3]}));
      chk(16'(icon_mode), 16'(ic));
      chk(16'(bias_sel), ic ? 16'h0002 : 16'(c[i][4]));
      chk(16'(page_addr), 16'(c[i][7:5]));
    end
  endtask : t_ctrl
  // Address byte then three data bytes across the wrap
  task automatic t_incr(input logic [7:0] ctl, input logic [7:0] ab, input logic [29:0] exp);
    open(ctl);
    send(ab, 1'b1);
    chk(16'({page_inc_mode, column_addr}), 16'(ab));
    for (int i = 2; i >= 0; i--) begin
      send(8'h5A, 1'b1);
      chk(16'({page_addr, column_addr}), 16'(exp[i*10 +: 10]));
    end
    m.stop();
    chk(16'({page_addr, column_addr}), 16'(exp[9:0]));
  endtask : t_incr
  // Cut bytes leave settings alone
  task automatic t_partial();
    m.start();
    send(SLV0, 1'b1);
    m.send_bits(8'hFF, 4);
    m.stop();
    chk(16'(display_on), 16'h0000);
    open(8'h09);
    m.send_bits(8'hFF, 5);
    m.stop();
    chk(16'({page_inc_mode, column_addr}), 16'h0080);
  endtask : t_partial
  task automatic wait_frame(output int n);
    logic f;
    f = frame_fr;
    n = 0;
    while (frame_fr === f && n < 400) begin
      @(negedge osc_clk);
      n++;
    end
  endtask : wait_frame
  // Frame length, then display off and power save
  task automatic t_frame();
    int n;
    logic [7:0] c [2];
    c = '{8'h00, 8'h03};
    wait_frame(n);
    chk(16'(com_drive_en), 16'h0001);
    wait_frame(n);
    chk(16'(n), 16'h0088);
    open(8'h01);
    m.stop();
    wait_frame(n);
    wait_frame(n);
    chk(16'(n), 16'h0088);
    foreach (c[i]) begin
      open(c[i]);
      m.stop();
      repeat (4) @(negedge osc_clk);
      chk(16'({com_drive_en, |segment_outputs}), 16'h0000);
    end
  endtask : t_frame
  // Icon row is page 4 bit 1
  task automatic t_icon();
    // Leave power save with the display still off
    open(8'h84);
    m.stop();
    chk(16'(com_drive_en), 16'h0000);
    open(8'h85);
    send(8'h00, 1'b1);
    send(8'h02, 1'b1);
    send(8'h00, 1'b1);
    m.stop();
    repeat (300) @(negedge osc_clk);
    chk(16'(segment_outputs[1:0]), 16'h0001);
    chk(16'(com_index), 16'h0021);
    chk(16'(com_half_level), 16'h0001);
  endtask : t_icon
  // Reset in mid byte, then a clean transfer
  task automatic t_abort();
    m.start();
    send(SLV0, 1'b1);
    m.send_bits(8'hFF, 3);
    do_reset();
    m.stop();
    open(8'h01);
    m.stop();
    chk(16'(display_on), 16'h0001);
  endtask : t_abort
  initial begin
    do_reset();
    t_slave();
    t_ctrl();
    t_incr(8'h80, 8'h63, {10'h264, 10'h000, 10'h001});
    t_incr(8'h60, 8'hE4, {10'h264, 10'h000, 10'h080});
    t_partial();
    t_frame();
    t_icon();
    t_abort();
    give_verdict();
  end
  // Hang guard, about a quarter past the expected run
  initial begin
    #950000;
    error_cnt++;
    give_verdict();
  end
endmodule : lcd_i2c_command_port_tb
